// ==== src/tasm_link.sv ====
// Link-clock side: takes host register requests and hands them to the core
`timescale 1ns/1ps
module tasm_link
  import tasm_pkg::*;
(
  // Link clock and reset
  input  wire logic       link_clk,
  input  wire logic       rstn,
  // Host request side
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       ara_ok,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            reg_busy,
  // Core handshake
  tasm_xfer_if.link       xfer
);
  tasm_link_st_t st_q, st_d;
  tasm_cmd_t     cmd_q, cmd_d;
  logic [7:0]    addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic          tgl_q, tgl_d, rvalid_q, rvalid_d, ack_s;

  tasm_sync #(.W(1)) u_ack_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    (xfer.ack_tgl),
    .q    (ack_s)
  );

  // --------------------------------------------------------------------------
  // Request sequencing
  // --------------------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    cmd_d    = cmd_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    tgl_d    = tgl_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    unique case (st_q)
      TASM_LINK_IDLE: begin
        if (reg_wr || reg_rd || ara_ok) begin
          // Write wins over read, read over alert response
          cmd_d   = reg_wr ? TASM_CMD_WR : (reg_rd ? TASM_CMD_RD : TASM_CMD_ARA);
          addr_d  = reg_addr;
          wdata_d = reg_wdata;
          tgl_d   = ~tgl_q;
          st_d    = TASM_LINK_WAIT;
        end
      end
      TASM_LINK_WAIT: begin
        if (ack_s == tgl_q) begin
          rdata_d  = xfer.rdata;
          rvalid_d = (cmd_q == TASM_CMD_RD);
          st_d     = TASM_LINK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= TASM_LINK_IDLE;
      cmd_q    <= TASM_CMD_RD;
      addr_q   <= RST_REG8;
      wdata_q  <= RST_REG8;
      tgl_q    <= 1'b0;
      rdata_q  <= RST_REG8;
      rvalid_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      cmd_q    <= cmd_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      tgl_q    <= tgl_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign xfer.req_tgl = tgl_q;
  assign xfer.cmd     = cmd_q;
  assign xfer.addr    = addr_q;
  assign xfer.wdata   = wdata_q;
  assign reg_rdata    = rdata_q;
  assign reg_rvalid   = rvalid_q;
  assign reg_busy     = (st_q == TASM_LINK_WAIT);
endmodule : tasm_link

// ==== src/tasm_pkg.sv ====
// Shared constants and types of the thermal alarm status and mask bank
package tasm_pkg;

  // --------------------------------------------------------------------------
  // Register command bytes
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_SHUT_MASK  = 8'h43;
  localparam logic [7:0] ADDR_HIGH_ALERT = 8'h44;
  localparam logic [7:0] ADDR_OVERTEMP   = 8'h45;
  localparam logic [7:0] ADDR_SNS_FAULT  = 8'h46;

  // --------------------------------------------------------------------------
  // Reset values and writable bits
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_REG8      = 8'h00;
  localparam logic [7:0] SHUT_MASK_WR  = 8'h09;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int CH1_SHUT_MASK_BIT = 0;
  localparam int CH4_SHUT_MASK_BIT = 3;
  localparam int HA_LOCAL_BIT      = 6;
  localparam int OT_CH1_BIT        = 0;
  localparam int OT_CH4_BIT        = 3;
  localparam int SF_FIRST_BIT      = 1;
  localparam int SF_UNUSED_LO_BIT  = 5;
  localparam int SF_UNUSED_HI_BIT  = 6;

  // --------------------------------------------------------------------------
  // Channels and thresholds
  // --------------------------------------------------------------------------
  localparam int         NUM_REMOTE  = 4;
  localparam logic [2:0] CHAN_R1     = 3'h0;
  localparam logic [2:0] CHAN_R4     = 3'h3;
  localparam logic [2:0] CHAN_LOCAL  = 3'h4;
  localparam logic [8:0] HYST_DEGC   = 9'h004;

  typedef enum logic [1:0] {TASM_CMD_WR, TASM_CMD_RD, TASM_CMD_ARA} tasm_cmd_t;
  typedef enum logic {TASM_LINK_IDLE, TASM_LINK_WAIT} tasm_link_st_t;

endpackage : tasm_pkg

// ==== src/tasm_status_bank.sv ====
// Alarm flag, mask and warning/shutdown output bank of a temperature monitor
`timescale 1ns/1ps

// Operation
// R01 - Channel-4 shutdown mask bit 3 set blocks channel-4 shutdown output; resets 0.
// R02 - Channel-1 shutdown mask bit 0 set blocks channel-1 shutdown output; resets 0.
// R03 - Local result above local alert limit sets high-alert bit 6.
// R04 - Channel-4 result above its alert limit sets high-alert bit 3.
// R05 - Channel-3 result above its alert limit sets high-alert bit 2.
// R06 - Channel-2 result above its alert limit sets high-alert bit 1.
// R07 - Channel-1 result above its alert limit sets high-alert bit 0.
// R08 - Channel-4 result above its shutdown limit sets overtemperature bit 3.
// R09 - Channel-1 result above its shutdown limit sets overtemperature bit 0.
// R10 - Channel-4 open or shorted-to-supply diode sets sensor-fault bit 4.
// R11 - Channel-3 open or shorted-to-supply diode sets sensor-fault bit 3.
// R12 - Channel-2 open or shorted-to-supply diode sets sensor-fault bit 2.
// R13 - Channel-1 open or shorted-to-supply diode sets sensor-fault bit 1.
// R14 - Sensor-fault bits 6 and 5 read 0 after power-on, 1 once running.
// R15 - High-alert flags clear on read and set again if fault remains.
// R16 - Warning follows alert flags; drops on read or alert response, then returns.
// R17 - Overtemperature flags clear only on read; read leaves shutdown output alone.
// R18 - Shutdown fault holds until temperature falls hysteresis below its limit.
// R19 - Reserved bits read 0 except unused fault bits; reserved writes ignored.
module tasm_status_bank
  import tasm_pkg::*;
(
  // Clocks and reset
  input  wire logic                 sys_clk,
  input  wire logic                 link_clk,
  input  wire logic                 rstn,

  // Conversion results from the sequencer
  input  wire logic                 conv_done,
  input  wire logic [2:0]           conv_chan,
  input  wire logic [7:0]           conv_temp,
  input  wire logic                 conv_open,

  // Limits held by the limit registers
  input  wire logic [4:0][7:0]      alert_limit,
  input  wire logic [7:0]           ch1_shut_limit,
  input  wire logic [7:0]           ch4_shut_limit,

  // Host register access, link clock domain
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic                 ara_ok,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  output logic                      reg_busy,

  // Open-drain outputs
  output logic                      warn_out_n,
  output logic                      warn_oe_n,
  output logic                      shutdown_out_n,
  output logic                      shutdown_oe_n
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic over_limit(input logic [7:0] t, input logic [7:0] lim);
    over_limit = (t > lim);
  endfunction : over_limit

  function automatic logic is_cmd(input tasm_cmd_t c, input logic [7:0] a,
                                  input tasm_cmd_t want, input logic [7:0] at);
    is_cmd = (c == want) && (a == at);
  endfunction : is_cmd

  function automatic logic [7:0] ha_onehot(input logic [2:0] ch);
    ha_onehot = '0;
    if (ch == CHAN_LOCAL) begin
      ha_onehot[HA_LOCAL_BIT] = 1'b1;
    end else begin
      ha_onehot[ch[1:0]] = 1'b1;
    end
  endfunction : ha_onehot

  // --------------------------------------------------------------------------
  // Link side and crossing
  // --------------------------------------------------------------------------
  tasm_xfer_if xfer ();

  tasm_link u_link (
    .link_clk   (link_clk),
    .rstn       (rstn),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .ara_ok     (ara_ok),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .reg_busy   (reg_busy),
    .xfer       (xfer.link)
  );

  // Command, address and write data stay put in the link until our ack
  // toggles back, so only the request toggle needs a synchroniser
  logic req_s;

  tasm_sync #(.W(1)) u_req_sync (
    .clk  (sys_clk),
    .rstn (rstn),
    .d    (xfer.req_tgl),
    .q    (req_s)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] mask_q, mask_d;
  logic [7:0] ha_q, ha_d;
  logic [7:0] ot_q, ot_d;
  logic [3:0] sf_q, sf_d;
  logic       run_q, run_d;
  logic [1:0] fault_q, fault_d;
  logic       ack_q, ack_d;
  logic [7:0] rdata_q, rdata_d;
  logic       warn_n_q, warn_n_d;
  logic       shut_n_q, shut_n_d;

  logic       op;
  logic [7:0] ha_set, ot_set;
  logic [1:0] ch_hit;
  logic [7:0] shut_lim [2];
  logic       ch1_shutdown_mask;
  logic       ch4_shutdown_mask;

  assign shut_lim[0] = ch1_shut_limit;
  assign shut_lim[1] = ch4_shut_limit;

  // Mask bits as they will stand after this edge, so a write acts at once
  assign ch1_shutdown_mask = mask_d[CH1_SHUT_MASK_BIT];
  assign ch4_shutdown_mask = mask_d[CH4_SHUT_MASK_BIT];

  // A new request is pending while the synced toggle differs from our ack
  assign op = (req_s != ack_q);

  // --------------------------------------------------------------------------
  // Shutdown fault tracking with hysteresis, one per shutdown channel
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_shut
      logic hot, cool;
      assign ch_hit[g] = conv_done && !conv_open &&
                         (conv_chan == ((g == 0) ? CHAN_R1 : CHAN_R4));
      assign hot  = over_limit(conv_temp, shut_lim[g]);
      assign cool = ({1'b0, conv_temp} + HYST_DEGC) <= {1'b0, shut_lim[g]};
      always_comb begin
        fault_d[g] = fault_q[g];
        if (ch_hit[g] && hot) begin
          fault_d[g] = 1'b1;
        end else if (ch_hit[g] && cool) begin
          fault_d[g] = 1'b0;                                              // R18
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Flag set terms from the current conversion
  // --------------------------------------------------------------------------
  always_comb begin
    ha_set = '0;
    ot_set = '0;
    if (conv_done && (conv_chan <= CHAN_LOCAL)) begin
      if (!conv_open || conv_chan == CHAN_LOCAL) begin
        if (over_limit(conv_temp, alert_limit[conv_chan])) begin
          ha_set = ha_onehot(conv_chan);                        // R03 R04 R05 R06 R07
        end
      end
    end
    if (ch_hit[0] && over_limit(conv_temp, ch1_shut_limit)) begin
      ot_set[OT_CH1_BIT] = 1'b1;                                          // R09
    end
    if (ch_hit[1] && over_limit(conv_temp, ch4_shut_limit)) begin
      ot_set[OT_CH4_BIT] = 1'b1;                                          // R08
    end
  end

  // --------------------------------------------------------------------------
  // Register file next state
  // --------------------------------------------------------------------------
  always_comb begin
    mask_d  = mask_q;
    ha_d    = ha_q;
    ot_d    = ot_q;
    sf_d    = sf_q;
    run_d   = run_q;
    ack_d   = ack_q;
    rdata_d = rdata_q;

    if (op) begin
      ack_d   = req_s;
      rdata_d = RD_UNMAPPED;
      if (is_cmd(xfer.cmd, xfer.addr, TASM_CMD_WR, ADDR_SHUT_MASK)) begin
        mask_d = xfer.wdata & SHUT_MASK_WR;                               // R19
      end

      if (xfer.cmd == TASM_CMD_RD) begin
        unique case (xfer.addr)
          ADDR_SHUT_MASK:  rdata_d = mask_q;
          ADDR_HIGH_ALERT: rdata_d = ha_q;
          ADDR_OVERTEMP:   rdata_d = ot_q;
          ADDR_SNS_FAULT: begin
            rdata_d = '0;                                                 // R19
            rdata_d[SF_UNUSED_LO_BIT] = run_q;                            // R14
            rdata_d[SF_UNUSED_HI_BIT] = run_q;                            // R14
            rdata_d[SF_FIRST_BIT +: NUM_REMOTE] = sf_q;
          end
          default:         rdata_d = RD_UNMAPPED;
        endcase
      end

      // Read clears happen after the old value is latched for the answer
      if (is_cmd(xfer.cmd, xfer.addr, TASM_CMD_RD, ADDR_HIGH_ALERT) ||
          xfer.cmd == TASM_CMD_ARA) begin
        ha_d = '0;                                                        // R15 R16
      end

      // Only the flags clear here; the shutdown pin follows the faults
      if (is_cmd(xfer.cmd, xfer.addr, TASM_CMD_RD, ADDR_OVERTEMP)) begin
        ot_d = '0;                                                        // R17
      end
    end

    // Sets win over a clear in the same cycle
    ha_d = ha_d | ha_set;                                                 // R15
    ot_d = ot_d | ot_set;

    if (conv_done) begin
      run_d = 1'b1;                                                       // R14
      if (conv_chan < CHAN_LOCAL) begin
        sf_d[conv_chan[1:0]] = conv_open;                                 // R10 R11 R12 R13
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output pins
  // --------------------------------------------------------------------------
  always_comb begin
    warn_n_d = ~(|ha_d);                                                  // R16
    shut_n_d = ~((fault_d[0] & ~ch1_shutdown_mask) |                      // R02
                 (fault_d[1] & ~ch4_shutdown_mask));                      // R01
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q   <= RST_REG8;                                               // R01 R02
      ha_q     <= RST_REG8;
      ot_q     <= RST_REG8;
      sf_q     <= '0;
      run_q    <= 1'b0;
      ack_q    <= 1'b0;
      rdata_q  <= RST_REG8;
    end else begin
      mask_q   <= mask_d;
      ha_q     <= ha_d;
      ot_q     <= ot_d;
      sf_q     <= sf_d;
      run_q    <= run_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
    end
  end

  // Faults are kept apart from the flags: a status read must not end them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Both pins released until a flag or an unmasked fault pulls them low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      warn_n_q <= 1'b1;
      shut_n_q <= 1'b1;
    end else begin
      warn_n_q <= warn_n_d;
      shut_n_q <= shut_n_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Read data stays stable until the next request, so the link may take it
  assign xfer.ack_tgl  = ack_q;
  assign xfer.rdata    = rdata_q;
  assign warn_out_n    = warn_n_q;
  assign warn_oe_n     = warn_n_q;
  assign shutdown_out_n = shut_n_q;
  assign shutdown_oe_n = shut_n_q;

endmodule : tasm_status_bank

// ==== src/tasm_sync.sv ====
// Three-stage synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
module tasm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

  if (W < 1) begin : g_bad_width
    $error("tasm_sync: W must be at least 1");
  end

  always_comb begin
    q_d = (s2_q == s3_q) ? s3_q : q_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q = q_q;
endmodule : tasm_sync

// ==== src/tasm_xfer_if.sv ====
// Request and answer handshake between the link side and the register core
`timescale 1ns/1ps
interface tasm_xfer_if;
  import tasm_pkg::*;
  logic            req_tgl;
  logic            ack_tgl;
  tasm_cmd_t       cmd;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;

  modport link (output req_tgl, cmd, addr, wdata, input ack_tgl, rdata);
  modport core (input req_tgl, cmd, addr, wdata, output ack_tgl, rdata);
endinterface : tasm_xfer_if

// ==== testbench/tasm_chk_assertions.sv ====
// Port checks of the alarm status bank
`timescale 1ns/1ps
module tasm_chk
  import tasm_pkg::*;
(
  // Clocks and reset
  input wire logic            sys_clk,
  input wire logic            link_clk,
  input wire logic            rstn,
  // Conversions
  input wire logic            conv_done,
  input wire logic [2:0]      conv_chan,
  input wire logic [7:0]      conv_temp,
  input wire logic            conv_open,
  input wire logic [4:0][7:0] alert_limit,
  input wire logic [7:0]      ch1_shut_limit,
  input wire logic [7:0]      ch4_shut_limit,
  // Register link
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_busy,
  // Pins
  input wire logic            warn_out_n,
  input wire logic            warn_oe_n,
  input wire logic            shutdown_out_n,
  input wire logic            shutdown_oe_n
);
  logic [1:0] mask_d;
  logic [1:0] mask_q;
  // Shadow of the shutdown masks, taken when a write is accepted
  always_comb begin
    mask_d = mask_q;
    if (reg_wr && !reg_busy && reg_addr == ADDR_SHUT_MASK) begin
      mask_d = {reg_wdata[CH4_SHUT_MASK_BIT], reg_wdata[CH1_SHUT_MASK_BIT]};
    end
  end
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= 2'b00;
    end else begin
      mask_q <= mask_d;
    end
  end
  // ----
  // Assertions
  // ----
  a_warn_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_done && conv_chan <= CHAN_LOCAL && (conv_chan == CHAN_LOCAL || !conv_open)
    && conv_temp > alert_limit[conv_chan] |=> !warn_oe_n && !warn_out_n)
    else $error("warn not driven");
  a_warn_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(warn_oe_n) |-> $past(conv_done)) else $error("warn without conversion");
  a_warn_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(warn_oe_n) |-> reg_busy || $past(reg_busy)) else $error("warn dropped unasked");
  a_shut_ch1_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_done && conv_chan == CHAN_R1 && !conv_open && conv_temp > ch1_shut_limit
    && !reg_busy && !mask_q[0] |=> !shutdown_oe_n && !shutdown_out_n)
    else $error("ch1 shutdown missing");
  a_shut_ch4_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_done && conv_chan == CHAN_R4 && !conv_open && conv_temp > ch4_shut_limit
    && !reg_busy && !mask_q[1] |=> !shutdown_oe_n && !shutdown_out_n)
    else $error("ch4 shutdown missing");
  a_mask_both: assert property (@(posedge sys_clk) disable iff (!rstn)
    !reg_busy && !$past(reg_busy) && mask_q == 2'b11 |-> shutdown_oe_n)
    else $error("masked shutdown driven");
  a_shut_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(shutdown_oe_n) |-> $past(conv_done) || reg_busy || $past(reg_busy))
    else $error("shutdown released unasked");
  a_shut_hyst: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(shutdown_oe_n) && !reg_busy && !$past(reg_busy) |-> !$past(conv_open)
    && ($past(conv_chan) == CHAN_R1 && {1'b0, $past(conv_temp)} + HYST_DEGC <= ch1_shut_limit
    || $past(conv_chan) == CHAN_R4 && {1'b0, $past(conv_temp)} + HYST_DEGC <= ch4_shut_limit))
    else $error("shutdown released early");
endmodule : tasm_chk

bind tasm_status_bank tasm_chk tasm_chk_i (.sys_clk, .link_clk, .rstn, .conv_done, .conv_chan,
  .conv_temp, .conv_open, .alert_limit, .ch1_shut_limit, .ch4_shut_limit, .reg_addr, .reg_wdata,
  .reg_wr, .reg_busy, .warn_out_n, .warn_oe_n, .shutdown_out_n, .shutdown_oe_n);

// ==== testbench/tasm_host.sv ====
// Host model issuing register requests on the link clock
`timescale 1ns/1ps
module tasm_host (
  // Clock
  input  wire logic       link_clk,
  // Requests
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            ara_ok,
  // Answers
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  input  wire logic       reg_busy
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {reg_wr, reg_rd, ara_ok} = 3'b000;
  end
  // Kind 0 write, 1 read, 2 alert response; ok stays low without an answer
  task automatic do_op(input int kind, input int gap, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] rd, output logic ok);
    logic got;
    rd = 8'h00;
    ok = 1'b0;
    got = (kind != 1);
    repeat (gap + 1) @(posedge link_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= (kind == 0);
    reg_rd <= (kind == 1);
    ara_ok <= (kind == 2);
    @(posedge link_clk);
    {reg_wr, reg_rd, ara_ok} <= 3'b000;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge link_clk);
      if (reg_rvalid) begin
        rd = reg_rdata;
        got = 1'b1;
      end
      ok = got && !reg_busy && n > 0;
    end
  endtask : do_op
endmodule : tasm_host

// ==== testbench/tb.sv ====
// Self-checking bench of the alarm status bank
`timescale 1ns/1ps
module tb;
  import tasm_pkg::*;
  logic            sys_clk, link_clk, rstn, conv_done, conv_open, reg_wr, reg_rd, ara_ok;
  logic [2:0]      conv_chan;
  logic [7:0]      conv_temp, ch1_shut_limit, ch4_shut_limit, reg_addr, reg_wdata, reg_rdata, v;
  logic [4:0][7:0] alert_limit;
  logic            reg_rvalid, reg_busy, warn_out_n, warn_oe_n, shutdown_out_n, shutdown_oe_n;
  int              failures, samples_checked, cycles, seed, r, k, lim;
  int              ha, ot, sf, mask, started, sh1, sh4;

  tasm_status_bank tasm_status_bank_i (.sys_clk, .link_clk, .rstn, .conv_done, .conv_chan,
    .conv_temp, .conv_open, .alert_limit, .ch1_shut_limit, .ch4_shut_limit, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .ara_ok, .reg_rdata, .reg_rvalid, .reg_busy, .warn_out_n,
    .warn_oe_n, .shutdown_out_n, .shutdown_oe_n);
  tasm_host tasm_host_i (.link_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .ara_ok,
    .reg_rdata, .reg_rvalid, .reg_busy);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("wrong value at %0t: run too long", $time);
      finish_test();
    end
  end

  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, want);
    end
  endtask : check

  function automatic int shut_next(int f, int t, int l);
    return (t > l) ? 1 : ((t + 4 <= l) ? 0 : f);
  endfunction : shut_next

  task automatic pins();
    logic w, s;
    @(negedge sys_clk);
    w = (warn_oe_n === 1'b0) ? warn_out_n : warn_oe_n;
    s = (shutdown_oe_n === 1'b0) ? shutdown_out_n : shutdown_oe_n;
    check({7'h00, w}, {7'h00, ha == 0}, "warn pin");
    check({7'h00, s}, {7'h00, !(sh1 && !mask[0] || sh4 && !mask[3])}, "shut pin");
  endtask : pins

  task automatic conv(input int ch, input int t, input int op);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    conv_chan <= ch[2:0];
    conv_temp <= t[7:0];
    conv_open <= op[0];
    @(posedge sys_clk);
    conv_done <= 1'b0;
    started = 1;
    if (ch < 4) sf[ch + 1] = op[0];
    if (ch == 4 || !op[0]) begin
      if (t > alert_limit[ch]) ha[ch == 4 ? 6 : ch] = 1;
      if (ch == 0 && t > ch1_shut_limit) ot[0] = 1;
      if (ch == 3 && t > ch4_shut_limit) ot[3] = 1;
      if (ch == 0) sh1 = shut_next(sh1, t, ch1_shut_limit);
      if (ch == 3) sh4 = shut_next(sh4, t, ch4_shut_limit);
    end
    pins();
  endtask : conv

  task automatic op(input int kind, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    logic [7:0] e;
    e = (a == ADDR_SHUT_MASK) ? mask[7:0] : (a == ADDR_HIGH_ALERT) ? ha[7:0] :
        (a == ADDR_OVERTEMP) ? ot[7:0] : (a == ADDR_SNS_FAULT) ? sf[7:0] | 8'(started * 96) : 8'h00;
    tasm_host_i.do_op(kind, $random(seed) & 3, a, d, v, ok);
    check({7'h00, ok}, 8'h01, "no answer");
    if (kind == 1) check(v, e, "read data");
    if (kind == 0 && a == ADDR_SHUT_MASK) mask = d & 8'h09;
    if (kind == 2 || kind == 1 && a == ADDR_HIGH_ALERT) ha = 0;
    if (kind == 1 && a == ADDR_OVERTEMP) ot = 0;
    repeat (2) @(posedge sys_clk);
    pins();
  endtask : op

  task automatic finish_test();
    $display("checked %0d values, %0d mismatches", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 1129;
    {conv_done, conv_open, conv_chan, conv_temp} = '0;
    for (int i = 0; i < 5; i++) alert_limit[i] = 8'(8'h50 + ($random(seed) & 63));
    ch1_shut_limit = 8'(8'h60 + ($random(seed) & 63));
    ch4_shut_limit = 8'(8'h60 + ($random(seed) & 63));
    rstn = 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int a = 8'h43; a <= 8'h47; a++) op(1, a[7:0], 8'h00);
    $display("test reset_values done");
    op(0, ADDR_SHUT_MASK, 8'hff);
    op(0, ADDR_HIGH_ALERT, 8'hff);
    op(1, ADDR_SHUT_MASK, 8'h00);
    op(1, ADDR_HIGH_ALERT, 8'h00);
    op(0, ADDR_SHUT_MASK, 8'h00);
    $display("test mask_write done");
    for (int ch = 0; ch < 5; ch++) begin
      conv(ch, alert_limit[ch], 0);
      conv(ch, alert_limit[ch] + 1, 0);
      op(1, ADDR_HIGH_ALERT, 8'h00);
      conv(ch, 8'hff, 0);
      op(2, 8'h00, 8'h00);
    end
    $display("test alert_flags done");
    conv(0, 0, 0);
    conv(3, 0, 0);
    for (int j = 0; j < 2; j++) begin
      lim = j ? ch4_shut_limit : ch1_shut_limit;
      conv(3 * j, lim + 1, 0);
      op(1, ADDR_OVERTEMP, 8'h00);
      op(1, ADDR_OVERTEMP, 8'h00);
      op(0, ADDR_SHUT_MASK, j ? 8'h08 : 8'h01);
      op(0, ADDR_SHUT_MASK, 8'h00);
      conv(3 * j, lim - 3, 0);
      conv(3 * j, lim - 4, 0);
    end
    $display("test shutdown done");
    for (int ch = 0; ch < 5; ch++) conv(ch, 8'hff, 1);
    op(1, ADDR_SNS_FAULT, 8'h00);
    op(1, ADDR_HIGH_ALERT, 8'h00);
    for (int ch = 0; ch < 4; ch++) conv(ch, 0, 0);
    op(1, ADDR_SNS_FAULT, 8'h00);
    $display("test sensor_fault done");
    repeat (120) begin
      r = $random(seed);
      k = (r >> 18) & 7;
      conv((r & 255) % 5, (r >> 8) & 255, ((r >> 16) & 3) == 0);
      if (k < 4) op(1, 8'(8'h43 + k), 8'h00);
      else if (k == 4) op(2, 8'h00, 8'h00);
      else if (k == 5) op(0, ADDR_SHUT_MASK, r[31:24]);
    end
    $display("test random_mix done");
    finish_test();
  end
endmodule : tb
